//--- pkg/sfe_pkg.sv
// constants, register map and carrier types of the nibble capture front end
// assumes one 200 MHz clock and an apb master with 32-bit data
package sfe_pkg;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned TICK_NS      = 3000;
  localparam int unsigned TICK_CYC     = TICK_NS * CLK_MHZ / 1000;
  localparam int unsigned FILT_NOM     = 5;
  localparam int unsigned FILT_PCT     = 75;
  localparam int unsigned TMO_NOM      = 56;
  localparam int unsigned TMO_PCT      = 125;
  // least interval rounds up, timeout compare is exact here
  localparam logic [15:0] FILT_TICKS   = 16'((FILT_NOM * FILT_PCT + 99) / 100);
  localparam logic [15:0] TMO_TICKS    = 16'(TMO_NOM * TMO_PCT / 100);
  localparam logic [3:0]  PRIO_TMO     = 4'hA;
  localparam logic [3:0]  PRIO_NIB     = 4'hB;
  localparam logic [3:0]  PRIO_NOTE    = 4'h1;
  localparam logic [7:0]  FRAME_RST    = 8'h09;
  localparam logic [15:0] TICKDIV_RST  = 16'(TICK_CYC);
  localparam logic [6:0]  WRAP_NARROW  = 7'h3F;
  localparam logic [6:0]  WRAP_WIDE    = 7'h7F;
  localparam logic [6:0]  STEP_NARROW  = 7'h02;
  localparam logic [6:0]  STEP_WIDE    = 7'h04;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_FRAME   = 12'h004;
  localparam logic [11:0] ADDR_TICKDIV = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00C;
  localparam logic [11:0] ADDR_NOTIFY  = 12'h010;
  localparam logic [11:0] ADDR_CAPT    = 12'h014;
  localparam logic [11:0] ADDR_DMA     = 12'h018;
  localparam logic [11:0] ADDR_BUF     = 12'h080;
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_WIDE    = 1;
  localparam int unsigned ST_FRAME     = 0;
  localparam int unsigned ST_TMO       = 1;
  localparam int unsigned ST_OVF       = 2;
  localparam int unsigned ST_NOTE      = 3;
  localparam int unsigned NOTE_FRAME   = 0;
  localparam int unsigned NOTE_ERR     = 1;

  typedef struct packed {
    logic timeout;
    logic nibble;
    logic notify;
  } sfe_irq_t;

  typedef struct packed {
    logic en;
    logic wide;
  } sfe_ctrl_t;
endpackage

//--- rtl/sfe_capture.sv
// nibble capture front end: tick timer, edge capture, glitch filter,
// timeout compare, request edge detector and wrapping dma buffer
// assumes sensor pin synchronous to pclk and an apb master
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sfe_capture
  import sfe_pkg::*;
#(
  parameter int unsigned TW = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        sensor_input_pin,
  output      logic        filter_event_line,
  output      logic        dma_request_line,
  output      sfe_irq_t    irq,
  output      logic [3:0]  irq_priority
);
  sfe_ctrl_t   ctrl;
  logic [7:0]  frame_nibble_count;
  logic [15:0] tick_div;
  logic [3:0]  status;
  logic [15:0] div_cnt;
  logic [TW-1:0] period_timer_cell;
  logic [TW-1:0] edge_capture_cell;
  logic        sensor_q;
  logic        tmo_hit;
  logic        event_q;
  logic [6:0]  dest;
  logic [7:0]  remain;
  logic [31:0] buffer [32];

  // apb decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire rd       = acc && !pwrite;
  wire in_buf   = paddr[11:7] == ADDR_BUF[11:7];
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_frm  = paddr == ADDR_FRAME;
  wire hit_div  = paddr == ADDR_TICKDIV;
  wire hit_st   = paddr == ADDR_STATUS;
  wire hit_note = paddr == ADDR_NOTIFY;
  wire hit_capt = paddr == ADDR_CAPT;
  wire hit_dma  = paddr == ADDR_DMA;
  wire mapped   = hit_ctrl || hit_frm || hit_div || hit_st || hit_note
                  || hit_capt || hit_dma || in_buf;
  wire [31:0] buf_word = buffer[paddr[6:2]];

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = !rd      ? 32'h0000_0000 :
                   hit_ctrl ? {30'h0, ctrl.wide, ctrl.en} :
                   hit_frm  ? {24'h0, frame_nibble_count} :
                   hit_div  ? {16'h0, tick_div} :
                   hit_st   ? {28'h0, status} :
                   hit_capt ? 32'(edge_capture_cell) :
                   hit_dma  ? {17'h0, remain, dest} :
                   in_buf   ? buf_word : 32'h0000_0000;

  // tick divider: one-cycle enable per nominal tick
  // compare is >= so a smaller divisor written mid-count cannot stall a full wrap
  wire tick     = ctrl.en && (div_cnt >= tick_div - 16'h0001);
  wire fall     = ctrl.en && sensor_q && !sensor_input_pin;
  wire tmo_now  = tick && !fall && !tmo_hit
                  && (period_timer_cell == TW'(TMO_TICKS) - TW'(1));
  wire pass     = fall && (period_timer_cell >= TW'(FILT_TICKS));
  wire req_rise = filter_event_line && !event_q;

  // request buffering: capture value queued per request
  logic        q_ready;
  logic        q_valid;
  logic [31:0] q_data;
  wire  wide    = ctrl.wide;
  wire  drain   = !(acc && in_buf);
  wire  mem_we  = q_valid && drain;
  wire  last    = (remain == 8'h01);
  wire  [6:0] step = wide ? STEP_WIDE : STEP_NARROW;
  wire  [6:0] wrap = wide ? WRAP_WIDE : WRAP_NARROW;
  wire  [6:0] next_dest = (dest + step) & wrap;
  wire  [7:0] next_remain = last ? frame_nibble_count : remain - 8'h01;

  sfe_fifo #(
    .W (32),
    .D (FIFO_DEPTH)
  ) sfe_fifo_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (dma_request_line),
    .in_ready  (q_ready),
    .in_data   (32'(edge_capture_cell)),
    .out_valid (q_valid),
    .out_ready (drain),
    .out_data  (q_data)
  );

  wire note_wr  = wr && hit_note;
  wire note_any = note_wr && (pwdata[NOTE_FRAME] || pwdata[NOTE_ERR]);
  wire [3:0] st_set = {note_any, dma_request_line && !q_ready,
                       tmo_now, mem_we && last};
  wire [3:0] st_clr = (wr && hit_st) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= '0;
      frame_nibble_count <= FRAME_RST;
      tick_div           <= TICKDIV_RST;
      status             <= 4'h0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl.en   <= pwdata[CTRL_EN];
        ctrl.wide <= pwdata[CTRL_WIDE];
      end
      if (wr && hit_frm && pwdata[7:0] != 8'h00) begin
        frame_nibble_count <= pwdata[7:0];
      end
      if (wr && hit_div && pwdata[15:0] != 16'h0000) begin
        tick_div <= pwdata[15:0];
      end
      // a flag raised in the clearing cycle survives
      status <= (status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else if (!ctrl.en || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // timer saturates instead of wrapping so a dead line stays timed out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_timer_cell <= '0;
      sensor_q          <= 1'b1;
    end else begin
      sensor_q <= sensor_input_pin;
      if (!ctrl.en || fall) begin
        period_timer_cell <= '0;
      end else if (tick && period_timer_cell != '1) begin
        period_timer_cell <= period_timer_cell + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_capture_cell <= '0;
      tmo_hit           <= 1'b0;
      filter_event_line <= 1'b0;
    end else begin
      if (fall) begin
        edge_capture_cell <= period_timer_cell;
      end
      // timeout holds until the next falling edge or until ctrl.en is cleared
      if (fall || !ctrl.en) begin
        tmo_hit <= 1'b0;
      end else if (tmo_now) begin
        tmo_hit <= 1'b1;
      end
      filter_event_line <= pass;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q          <= 1'b0;
      dma_request_line <= 1'b0;
    end else begin
      event_q          <= filter_event_line;
      dma_request_line <= req_rise;
    end
  end

  // dma channel: fixed source, wrapping destination, continuous count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest   <= 7'h00;
      remain <= FRAME_RST;
    end else if (!ctrl.en) begin
      dest   <= 7'h00;
      remain <= frame_nibble_count;
    end else if (mem_we) begin
      dest   <= next_dest;
      remain <= next_remain;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      if (wide) begin
        buffer[dest[6:2]] <= q_data;
      end else if (dest[1]) begin
        buffer[dest[6:2]][31:16] <= q_data[15:0];
      end else begin
        buffer[dest[6:2]][15:0] <= q_data[15:0];
      end
    end
  end

  // interrupt pulses; priority holds the highest source of the latest interrupt cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq          <= '0;
      irq_priority <= 4'h0;
    end else begin
      irq.timeout <= tmo_now;
      irq.nibble  <= mem_we && last;
      irq.notify  <= note_any;
      if (mem_we && last) begin
        irq_priority <= PRIO_NIB;
      end else if (tmo_now) begin
        irq_priority <= PRIO_TMO;
      end else if (note_any) begin
        irq_priority <= PRIO_NOTE;
      end
    end
  end

  property p_timer_clear;
    @(posedge pclk) disable iff (!presetn)
    fall |=> period_timer_cell == '0;
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer not cleared by capture");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    fall |=> edge_capture_cell == $past(period_timer_cell);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture does not hold timer value");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
    fall |=> filter_event_line == (edge_capture_cell >= TW'(FILT_TICKS));
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter event disagrees with threshold");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    tmo_now |=> irq.timeout && period_timer_cell == TW'(TMO_TICKS) && irq_priority != 4'h0;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout not raised at compare value");

  property p_request;
    @(posedge pclk) disable iff (!presetn)
    $rose(filter_event_line) |=> dma_request_line ##1 !dma_request_line;
  endproperty
  a_request: assert property (p_request)
    else $error("request not a single pulse per event");

  property p_narrow;
    @(posedge pclk) disable iff (!presetn)
    mem_we && ctrl.en && !wide |=> dest == (($past(dest) + 7'h02) & 7'h3F);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow destination step or wrap wrong");

  property p_count;
    @(posedge pclk) disable iff (!presetn)
    mem_we && ctrl.en && last |=> irq.nibble && irq_priority == PRIO_NIB
      && remain == frame_nibble_count;
  endproperty
  a_count: assert property (p_count)
    else $error("nibble interrupt missing at count zero");

  property p_wide;
    @(posedge pclk) disable iff (!presetn)
    mem_we && ctrl.en && wide |=> dest == (($past(dest) + 7'h04) & 7'h7F);
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide destination step or wrap wrong");

  property p_notify;
    @(posedge pclk) disable iff (!presetn)
    note_any |=> irq.notify ##1 !irq.notify;
  endproperty
  a_notify: assert property (p_notify)
    else $error("notification pulse missing");

  property p_frame_len;
    @(posedge pclk) disable iff (!presetn)
    !ctrl.en ##1 !ctrl.en |-> remain == $past(frame_nibble_count);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("transaction length not frame count");

  property p_timer_hold;
    @(posedge pclk) disable iff (!presetn)
    ctrl.en && !fall && !tick |=> period_timer_cell == $past(period_timer_cell);
  endproperty
  a_timer_hold: assert property (p_timer_hold)
    else $error("timer moved without a tick");

  property p_timer_step;
    @(posedge pclk) disable iff (!presetn)
    ctrl.en && tick && !fall && period_timer_cell != '1
      |=> period_timer_cell == $past(period_timer_cell) + TW'(1);
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer missed a tick");

  property p_event_src;
    @(posedge pclk) disable iff (!presetn)
    filter_event_line |-> $past(fall);
  endproperty
  a_event_src: assert property (p_event_src)
    else $error("filter event without a captured edge");

  property p_req_clear;
    @(posedge pclk) disable iff (!presetn)
    dma_request_line |=> !dma_request_line;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("request flag did not clear itself");

  property p_step_hold;
    @(posedge pclk) disable iff (!presetn)
    ctrl.en && !mem_we |=> dest == $past(dest);
  endproperty
  a_step_hold: assert property (p_step_hold)
    else $error("destination moved without a transfer");

  property p_status_frame;
    @(posedge pclk) disable iff (!presetn)
    mem_we && last |=> status[ST_FRAME];
  endproperty
  a_status_frame: assert property (p_status_frame)
    else $error("transaction done flag not set");

  property p_status_tmo;
    @(posedge pclk) disable iff (!presetn)
    tmo_now |=> status[ST_TMO];
  endproperty
  a_status_tmo: assert property (p_status_tmo)
    else $error("timeout flag not set");

  property p_notify_prio;
    @(posedge pclk) disable iff (!presetn)
    note_any && !tmo_now && !(mem_we && last) |=> irq_priority == PRIO_NOTE;
  endproperty
  a_notify_prio: assert property (p_notify_prio)
    else $error("notification priority wrong");
endmodule

//--- rtl/sfe_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes both sides on pclk; full and empty are exact
`timescale 1ns/1ps
module sfe_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   fill;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (fill != (AW+1)'(D));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

//--- testbench/sfe_capture_tb.sv
// self-checking bench of the nibble capture front end
// assumes the sensor model in its own file; apb answers are awaited, not timed
`timescale 1ns/1ps
module sfe_capture_tb;
  import sfe_pkg::*;
  localparam int TD = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        edge_req = 1'b0;
  logic        evt_q = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, sensor_pin, filter_event_line, dma_request_line, err;
  sfe_irq_t    irq;
  logic [3:0]  irq_priority;
  logic [31:0] lfsr = 32'h3EB0095E;
  logic [15:0] cap [32];
  int          cyc = 0, t = 0, k = 0, mismatches = 0, check_count = 0;
  int          n_evt = 0, n_req = 0, n_tmo = 0, n_nib = 0, n_note = 0;

  always #2.5 pclk = ~pclk;

  sfe_capture sfe_capture_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensor_input_pin(sensor_pin), .filter_event_line(filter_event_line),
    .dma_request_line(dma_request_line), .irq(irq), .irq_priority(irq_priority));
  sfe_sensor_model sfe_sensor_model_inst (.pclk(pclk), .presetn(presetn), .edge_req(edge_req),
    .sensor_pin(sensor_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // pulse counters sample the registered outputs at every rising edge of pclk
  always @(posedge pclk) begin
    cyc   <= cyc + 1;
    evt_q <= filter_event_line;
    if (filter_event_line === 1'b1) n_evt <= n_evt + 1;
    if (dma_request_line === 1'b1) n_req <= n_req + 1;
    if (irq.timeout === 1'b1) n_tmo <= n_tmo + 1;
    if (irq.nibble === 1'b1) n_nib <= n_nib + 1;
    if (irq.notify === 1'b1) n_note <= n_note + 1;
    if (dma_request_line === 1'b1) check(32'(evt_q), 32'h1);
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic wait_cyc(input int tt);
    do @(posedge pclk); while (cyc < tt);
  endtask

  // edge spacing is exact in cycles because t marks the request edge
  task automatic edge_at(input int tt);
    wait_cyc(tt);
    t = cyc;
    edge_req <= 1'b1;
    @(posedge pclk);
    edge_req <= 1'b0;
  endtask

  task automatic nibble(input int i, input int kk);
    edge_at(t + kk * TD);
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_CAPT, 32'h0000_0000);
    check(32'(rd >= 32'(kk - 1) && rd <= 32'(kk)), 32'h1);
    cap[i] = rd[15:0];
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_CTRL, 32'h0000_0000);
    rchk(ADDR_FRAME, 32'h0000_0009);
    rchk(ADDR_TICKDIV, 32'h0000_0258);
    // a zero frame length is refused and the reset length stays
    apb(1'b1, ADDR_FRAME, 32'h0000_0000);
    rchk(ADDR_FRAME, 32'h0000_0009);
    rchk(ADDR_STATUS, 32'h0000_0000);
    rchk(12'h040, 32'h0000_0000);
    check(32'(err), 32'h1);
    apb(1'b1, ADDR_TICKDIV, 32'(TD));
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    // first edge right after enable is a short glitch interval
    edge_at(cyc + 2);
    repeat (8) @(posedge pclk);
    check(32'(n_evt), 32'h0);
    for (int i = 0; i < 32; i++) begin
      lfsr = lfsr_next(lfsr);
      k = 12 + int'(lfsr[3:0]);
      nibble(i, k);
    end
    repeat (8) @(posedge pclk);
    check(32'(irq_priority), 32'h0000_000B);
    check(32'(n_evt), 32'h0000_0020);
    check(32'(n_req), 32'h0000_0020);
    check(32'(n_nib), 32'h0000_0003);
    rchk(ADDR_DMA, 32'h0000_0200);
    for (int w = 0; w < 16; w++) begin
      rchk(ADDR_BUF + 12'(4 * w), {cap[2 * w + 1], cap[2 * w]});
    end
    rchk(ADDR_STATUS, 32'h0000_0001);
    apb(1'b1, ADDR_STATUS, 32'h0000_000F);
    rchk(ADDR_STATUS, 32'h0000_0000);
    wait_cyc(t + 100 * TD);
    check(32'(n_tmo), 32'h1);
    check(32'(irq_priority), 32'h0000_000A);
    rchk(ADDR_STATUS, 32'h0000_0002);
    wait_cyc(t + 180 * TD);
    check(32'(n_tmo), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    edge_at(cyc + 2);
    nibble(0, 16);
    nibble(1, 16);
    repeat (8) @(posedge pclk);
    rchk(ADDR_DMA, 32'h0000_0388);
    rchk(ADDR_BUF, {16'h0000, cap[0]});
    rchk(ADDR_BUF + 12'h004, {16'h0000, cap[1]});
    apb(1'b1, ADDR_NOTIFY, 32'h0000_0001);
    apb(1'b1, ADDR_NOTIFY, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    check(32'(n_note), 32'h2);
    check(32'(irq_priority), 32'h0000_0001);
    print_verdict();
  end
endmodule

//--- testbench/sfe_sensor_model.sv
// sensor model: one falling edge per request, fixed low phase, then idle high
// assumes requests at least LOW_CYC+1 cycles apart, all on pclk
`timescale 1ns/1ps
module sfe_sensor_model #(
  parameter int unsigned LOW_CYC = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic edge_req,
  output      logic sensor_pin
);
  logic [7:0] low_cnt;
  // push-pull driver, so the line is never left floating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_pin <= 1'b1;
      low_cnt    <= 8'h00;
    end else if (edge_req) begin
      sensor_pin <= 1'b0;
      low_cnt    <= 8'(LOW_CYC);
    end else if (low_cnt > 8'h01) begin
      low_cnt <= low_cnt - 8'h01;
    end else begin
      sensor_pin <= 1'b1;
      low_cnt    <= 8'h00;
    end
  end
endmodule
